/* verilog/mailbox_pkg.sv */
// Purpose: Shared constants for the slave port mailbox
// Assumes: Byte-wide link, two register-select lines
// Notes:   Select value three reaches the status register
package mailbox_pkg;
    localparam int          DATA_WIDTH     = 8;
    localparam int          SEL_WIDTH      = 2;
    localparam int          NUM_DATA       = 3;
    localparam logic [1:0]  SEL_DATA0      = 2'h0;
    localparam logic [1:0]  SEL_DATA1      = 2'h1;
    localparam logic [1:0]  SEL_DATA2      = 2'h2;
    localparam logic [1:0]  SEL_STATUS     = 2'h3;
    localparam int          ST_TO_SLAVE_LO = 0;
    localparam int          ST_TO_MASTER_LO = 4;
    localparam int          ST_MASTER_IRQ  = 3;
    localparam int          ST_SLAVE_IRQ   = 7;
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    localparam logic [7:0]  DATA_RESET     = 8'h00;
    localparam logic [1:0]  BOOT_FROM_PORT = 2'h1;
    localparam int          STROBE_CYCLES  = 4;
endpackage : mailbox_pkg

/* verilog/mailbox_link_if.sv */
// Purpose: Pins between the external master and the slave port
// Assumes: Master drives select, strobes and address; data is shared
// Notes:   Output enables are active low; the wire resolves here
`timescale 1ns/100ps
interface mailbox_link_if;
    logic                 port_select_n;
    logic                 master_read_strobe_n;
    logic                 master_write_strobe_n;
    logic                 reg_select_lo;
    logic                 reg_select_hi;
    logic                 attention_request_n;
    logic [7:0]           master_data_out;
    logic                 master_data_oe_n;
    logic [7:0]           slave_data_out;
    logic                 slave_data_oe_n;
    logic [7:0]           link_data;

    always_comb begin
        if (!slave_data_oe_n) begin
            link_data = slave_data_out;
        end else if (!master_data_oe_n) begin
            link_data = master_data_out;
        end else begin
            link_data = 8'hff;
        end
    end

    modport device (
        input  port_select_n, master_read_strobe_n, master_write_strobe_n,
        input  reg_select_lo, reg_select_hi, link_data,
        output attention_request_n, slave_data_out, slave_data_oe_n
    );
    modport master (
        output port_select_n, master_read_strobe_n, master_write_strobe_n,
        output reg_select_lo, reg_select_hi, master_data_out, master_data_oe_n,
        input  attention_request_n, link_data
    );
endinterface : mailbox_link_if

/* verilog/slave_port_mailbox.sv */
// Purpose: Device end of the mailbox port, with a local register bus
// Assumes: Master strobes are asynchronous to pclk and last several cycles
// Notes:   Local side reaches byte offsets 0x0, 0x4, 0x8 (data) and 0xC (status) over APB
//
// Function
// - Three data registers each direction, six
// - Status readable by master and local
// - Master drives two register select lines
// - Separate storage per direction per address
// - Master write fills to-slave register
// - Master read drives to-master data or status
// - Master may also write status register
// - Local write register zero asserts attention
// - Master write zero interrupts local if enabled
// - Only register zero writes raise interrupts
// - Full flags: set on write, clear on read
// - Identical rewrite still sets full flag
// - Status reports pending interrupts both sides
// - Sender loads one, two, then zero
// - Boot mode zero-one selects port boot
// - Data lines shared with general port
// - Accesses only while select low
// - Strobes active low, one per access
// - Attention output active low
`timescale 1ns/100ps
module slave_port_mailbox (
    input  wire logic        pclk,
    input  wire logic        presetn,
    mailbox_link_if.device   link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        port_enable,
    input  wire logic        local_irq_enable,
    output logic             local_irq,
    input  wire logic        boot_mode_lo,
    input  wire logic        boot_mode_hi,
    output logic             boot_from_port,
    input  wire logic [7:0]  gpio_out,
    input  wire logic        gpio_oe_n
);
    localparam int NS = 5;

    // Two-stage synchronisers for every master pin
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic [7:0]    dsync1_reg;
    logic [7:0]    dsync2_reg;
    logic [NS-1:0] sync_prev_reg;
    logic          boot_seen_reg;
    logic          boot_from_port_reg;
    logic          boot_from_port_next;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg     <= 5'h1f;
            sync2_reg     <= 5'h1f;
            sync_prev_reg <= 5'h1f;
            dsync1_reg    <= 8'h00;
            dsync2_reg    <= 8'h00;
        end else begin
            sync1_reg     <= {link.port_select_n, link.master_read_strobe_n,
                              link.master_write_strobe_n, link.reg_select_hi, link.reg_select_lo};
            sync2_reg     <= sync1_reg;
            sync_prev_reg <= sync2_reg;
            dsync1_reg    <= link.link_data;
            dsync2_reg    <= dsync1_reg;
        end
    end

    logic       sel_n_s;
    logic       rd_n_s;
    logic [1:0] addr_s;
    logic       wr_done;
    logic       rd_start;
    logic       rd_done;
    assign sel_n_s = sync2_reg[4];
    assign rd_n_s  = sync2_reg[3];
    assign addr_s  = sync2_reg[1:0];
    // Writes commit on the strobe's rising edge so data has settled
    assign wr_done  = port_enable && !sync_prev_reg[2] && sync2_reg[2] && !sync_prev_reg[4];
    assign rd_start = port_enable && sync_prev_reg[3] && !rd_n_s && !sel_n_s;
    assign rd_done  = port_enable && !sync_prev_reg[3] && rd_n_s && !sync_prev_reg[4];

    // Storage: index 0..2 per direction
    logic [7:0] to_slave_reg  [mailbox_pkg::NUM_DATA];
    logic [7:0] to_master_reg [mailbox_pkg::NUM_DATA];
    logic [7:0] to_slave_next [mailbox_pkg::NUM_DATA];
    logic [7:0] to_master_next[mailbox_pkg::NUM_DATA];
    logic [2:0] ts_full_reg, ts_full_next;
    logic [2:0] tm_full_reg, tm_full_next;
    logic       local_irq_reg, local_irq_next;
    logic       attn_reg, attn_next;
    logic [7:0] out_reg, out_next;
    logic [7:0] status;

    logic       apb_acc;
    logic       apb_wr;
    logic       apb_rd;
    logic [1:0] apb_idx;
    logic       apb_hit;
    assign apb_acc = psel && penable;
    assign apb_hit = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
    assign apb_idx = paddr[3:2];
    assign apb_wr  = apb_acc && pwrite && apb_hit;
    assign apb_rd  = apb_acc && !pwrite && apb_hit;

    always_comb begin
        status = mailbox_pkg::STATUS_RESET;
        status[mailbox_pkg::ST_TO_SLAVE_LO +: 3]  = ts_full_reg;
        status[mailbox_pkg::ST_TO_MASTER_LO +: 3] = tm_full_reg;
        status[mailbox_pkg::ST_MASTER_IRQ]        = local_irq_reg;
        status[mailbox_pkg::ST_SLAVE_IRQ]         = attn_reg;
    end

    always_comb begin
        to_slave_next  = to_slave_reg;
        to_master_next = to_master_reg;
        ts_full_next   = ts_full_reg;
        tm_full_next   = tm_full_reg;
        local_irq_next = local_irq_reg;
        attn_next      = attn_reg;
        out_next       = out_reg;
        // Clears first, so a same-cycle set wins
        if (apb_rd && apb_idx != mailbox_pkg::SEL_STATUS) begin
            ts_full_next[apb_idx] = 1'b0;
            if (apb_idx == mailbox_pkg::SEL_DATA0) begin
                local_irq_next = 1'b0;
            end
        end
        if (rd_done && addr_s != mailbox_pkg::SEL_STATUS) begin
            tm_full_next[addr_s] = 1'b0;
            if (addr_s == mailbox_pkg::SEL_DATA0) begin
                attn_next = 1'b0;
            end
        end
        if (wr_done && addr_s == mailbox_pkg::SEL_STATUS) begin
            // Master status write acknowledges pending local interrupt
            local_irq_next = 1'b0;
        end
        if (apb_wr && apb_idx != mailbox_pkg::SEL_STATUS) begin
            to_master_next[apb_idx] = pwdata[7:0];
            tm_full_next[apb_idx]   = 1'b1;
            if (apb_idx == mailbox_pkg::SEL_DATA0) begin
                attn_next = 1'b1;
            end
        end
        if (wr_done && addr_s != mailbox_pkg::SEL_STATUS) begin
            to_slave_next[addr_s] = dsync2_reg;
            ts_full_next[addr_s]  = 1'b1;
            if (addr_s == mailbox_pkg::SEL_DATA0 && local_irq_enable) begin
                local_irq_next = 1'b1;
            end
        end
        if (rd_start) begin
            out_next = (addr_s == mailbox_pkg::SEL_STATUS) ? status : to_master_reg[addr_s];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < mailbox_pkg::NUM_DATA; i++) begin
                to_slave_reg[i]  <= mailbox_pkg::DATA_RESET;
                to_master_reg[i] <= mailbox_pkg::DATA_RESET;
            end
            ts_full_reg   <= 3'h0;
            tm_full_reg   <= 3'h0;
            local_irq_reg <= 1'b0;
            attn_reg      <= 1'b0;
            out_reg       <= 8'h00;
        end else begin
            to_slave_reg  <= to_slave_next;
            to_master_reg <= to_master_next;
            ts_full_reg   <= ts_full_next;
            tm_full_reg   <= tm_full_next;
            local_irq_reg <= local_irq_next;
            attn_reg      <= attn_next;
            out_reg       <= out_next;
        end
    end

    // Straps are static through reset, so these unreset flops are full by release
    logic [1:0] boot_sync1_reg;
    logic [1:0] boot_sync2_reg;
    always_ff @(posedge pclk) begin
        boot_sync1_reg <= {boot_mode_hi, boot_mode_lo};
        boot_sync2_reg <= boot_sync1_reg;
    end

    // Boot strap caught on the first edge after release
    always_comb begin
        boot_from_port_next = boot_from_port_reg;
        if (!boot_seen_reg) begin
            boot_from_port_next = (boot_sync2_reg == mailbox_pkg::BOOT_FROM_PORT);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_seen_reg      <= 1'b0;
            boot_from_port_reg <= 1'b0;
        end else begin
            boot_seen_reg      <= 1'b1;
            boot_from_port_reg <= boot_from_port_next;
        end
    end

    logic port_drive;
    assign port_drive = port_enable && !sel_n_s && !rd_n_s;

    // Drive lags the strobe by two cycles each way; the master's hold phase covers the tail
    assign link.slave_data_out      = port_enable ? out_reg : gpio_out;
    assign link.slave_data_oe_n     = port_enable ? !port_drive : gpio_oe_n;
    assign link.attention_request_n = !attn_reg;

    assign local_irq      = local_irq_reg;
    assign boot_from_port = boot_from_port_reg;
    assign pready         = 1'b1;
    assign pslverr        = apb_acc && !apb_hit;
    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_rd) begin
            prdata[7:0] = (apb_idx == mailbox_pkg::SEL_STATUS) ? status : to_slave_reg[apb_idx];
        end
    end
endmodule : slave_port_mailbox

/* verilog/mailbox_master.sv */
// Purpose: Master end driving the mailbox port pins from simple requests
// Assumes: Same pclk as the bench; strobe length is a parameter
// Notes:   One request at a time; req_ready low while busy
`timescale 1ns/100ps
module mailbox_master #(
    parameter int STROBE = mailbox_pkg::STROBE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    mailbox_link_if.master   link,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_sel,
    input  wire logic [7:0]  req_wdata,
    output logic             rsp_valid,
    output logic [7:0]       rsp_rdata,
    output logic             attention
);
    typedef enum logic [1:0] {IDLE_S = 2'b00, SETUP_S = 2'b01, STROBE_S = 2'b11, HOLD_S = 2'b10} state_type;
    state_type  state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;
    logic       wr_reg, wr_next;
    logic [1:0] sel_reg, sel_next;
    logic [7:0] data_reg, data_next;
    logic       rsp_reg, rsp_next;
    logic       att1_reg, att2_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        wr_next    = wr_reg;
        sel_next   = sel_reg;
        data_next  = data_reg;
        rsp_next   = 1'b0;
        unique case (state_reg)
            IDLE_S: begin
                if (req_valid) begin
                    wr_next    = req_write;
                    sel_next   = req_sel;
                    data_next  = req_wdata;
                    state_next = SETUP_S;
                end
            end
            SETUP_S: begin
                cnt_next   = 8'(STROBE);
                state_next = STROBE_S;
            end
            STROBE_S: begin
                cnt_next = cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    if (!wr_reg) begin
                        data_next = link.link_data;
                    end
                    state_next = HOLD_S;
                end
            end
            HOLD_S: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == 8'(STROBE)) begin
                    rsp_next   = 1'b1;
                    state_next = IDLE_S;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IDLE_S;
            cnt_reg   <= 8'h00;
            wr_reg    <= 1'b0;
            sel_reg   <= 2'h0;
            data_reg  <= 8'h00;
            rsp_reg   <= 1'b0;
            att1_reg  <= 1'b1;
            att2_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            wr_reg    <= wr_next;
            sel_reg   <= sel_next;
            data_reg  <= data_next;
            rsp_reg   <= rsp_next;
            att1_reg  <= link.attention_request_n;
            att2_reg  <= att1_reg;
        end
    end

    logic active;
    logic strobing;
    assign active   = (state_reg != IDLE_S);
    assign strobing = (state_reg == STROBE_S);
    // Select spans the whole access so the slave sees it around the strobe edge
    assign link.port_select_n         = !active;
    assign link.master_write_strobe_n = !(strobing && wr_reg);
    assign link.master_read_strobe_n  = !(strobing && !wr_reg);
    assign link.reg_select_lo         = sel_reg[0];
    assign link.reg_select_hi         = sel_reg[1];
    assign link.master_data_out       = data_reg;
    assign link.master_data_oe_n      = !(active && wr_reg);
    assign req_ready = !active;
    assign rsp_valid = rsp_reg;
    assign rsp_rdata = data_reg;
    assign attention = !att2_reg;
endmodule : mailbox_master

/* testbench/mailbox_link_sva.sv */
// Purpose: Assertions on the mailbox link pins
// Assumes: Both ends share pclk; master strobes last four cycles
// Notes:   Sees pins only; local bus effects are judged by the bench
`timescale 1ns/100ps
module mailbox_link_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic port_select_n,
    input wire logic master_read_strobe_n,
    input wire logic master_write_strobe_n,
    input wire logic reg_select_lo,
    input wire logic reg_select_hi,
    input wire logic attention_request_n,
    input wire logic master_data_oe_n,
    input wire logic slave_data_oe_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [1:0] sel;
    assign sel = {reg_select_hi, reg_select_lo};

    idle_attention_a: assert property ($rose(presetn) |-> attention_request_n)
        else $error("attention low right after reset");
    idle_quiet_a: assert property (port_select_n |-> slave_data_oe_n)
        else $error("device drives data while not selected");
    write_quiet_a: assert property (!master_write_strobe_n |-> slave_data_oe_n && !master_data_oe_n)
        else $error("wrong data driver during write strobe");
    read_drive_a: assert property ($fell(master_read_strobe_n) && !port_select_n |-> ##[1:4] !slave_data_oe_n)
        else $error("device never drove read data");
    attn_clear_a: assert property ($rose(master_read_strobe_n) && !port_select_n && sel == 2'h0
        |-> ##[0:5] attention_request_n)
        else $error("attention not cleared by read of register zero");
    strobe_len_a: assert property ($fell(master_write_strobe_n) |-> !master_write_strobe_n [*4] ##1 master_write_strobe_n)
        else $error("write strobe length wrong");
    strobe_excl_a: assert property (!(!master_read_strobe_n && !master_write_strobe_n))
        else $error("both strobes low");
    select_frame_a: assert property (!master_read_strobe_n || !master_write_strobe_n
        |-> !port_select_n && $stable(sel))
        else $error("strobe outside select or address moved");

    cover property ($fell(master_write_strobe_n));
    cover property ($fell(master_read_strobe_n));
    cover property ($fell(attention_request_n));
endmodule : mailbox_link_sva

/* testbench/testbench.sv */
// Purpose: Self-checking bench joining both mailbox ends
// Assumes: Port enabled except in the port disable test; straps at port boot until the second reset
// Notes:   Local side over APB, master side through request handshake
`timescale 1ns/100ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata_q;
    logic        local_irq_enable, local_irq, boot_from_port, err_q, port_enable, boot_mode_lo;
    logic        req_valid, req_ready, req_write, rsp_valid, attention;
    logic [1:0]  req_sel;
    logic [7:0]  req_wdata, rsp_rdata, link_q, gpio_out;
    int          miscompares, checked;

    mailbox_link_if mailbox_link_if_i();
    slave_port_mailbox slave_port_mailbox_i (.pclk(pclk), .presetn(presetn), .link(mailbox_link_if_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_enable(port_enable), .local_irq_enable(local_irq_enable),
        .local_irq(local_irq), .boot_mode_lo(boot_mode_lo), .boot_mode_hi(1'b0), .boot_from_port(boot_from_port),
        .gpio_out(gpio_out), .gpio_oe_n(1'b1));
    mailbox_master mailbox_master_i (.pclk(pclk), .presetn(presetn), .link(mailbox_link_if_i),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_sel(req_sel),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .attention(attention));
    mailbox_link_sva mailbox_link_sva_i (.pclk(pclk), .presetn(presetn),
        .port_select_n(mailbox_link_if_i.port_select_n),
        .master_read_strobe_n(mailbox_link_if_i.master_read_strobe_n),
        .master_write_strobe_n(mailbox_link_if_i.master_write_strobe_n),
        .reg_select_lo(mailbox_link_if_i.reg_select_lo), .reg_select_hi(mailbox_link_if_i.reg_select_hi),
        .attention_request_n(mailbox_link_if_i.attention_request_n),
        .master_data_oe_n(mailbox_link_if_i.master_data_oe_n),
        .slave_data_oe_n(mailbox_link_if_i.slave_data_oe_n));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Zero-wait slave, but the loop still waits on pready rather than assume it
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata_q = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Two spare cycles let synchronised flags settle before the next look
    task link(input logic wr, input logic [1:0] s, input logic [7:0] d);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_sel   <= s;
        req_wdata <= d;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge pclk); while (rsp_valid !== 1'b1);
        link_q = rsp_rdata;
        repeat (2) @(posedge pclk);
    endtask : link

    task close_out;
        $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        presetn          = 1'b0;
        psel             = 1'b0;
        penable          = 1'b0;
        pwrite           = 1'b0;
        paddr            = 12'h000;
        pwdata           = 32'h0;
        local_irq_enable = 1'b0;
        port_enable      = 1'b1;
        boot_mode_lo     = 1'b1;
        gpio_out         = 8'h00;
        req_valid        = 1'b0;
        req_write        = 1'b0;
        req_sel          = 2'h0;
        req_wdata        = 8'h00;
        miscompares      = 0;
        checked          = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(boot_from_port, 1'b1);
        check(mailbox_link_if_i.attention_request_n, 1'b1);
        check(attention, 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h0);
        check(err_q, 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        check(rdata_q, 32'h0);
        $display("Test reset done");
        local_irq_enable <= 1'b1;
        link(1'b1, 2'h1, 8'ha5);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h02);
        check(local_irq, 1'b0);
        link(1'b1, 2'h2, 8'h3c);
        link(1'b1, 2'h0, 8'h81);
        check(local_irq, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h0f);
        link(1'b0, 2'h3, 8'h00);
        check(link_q, 8'h0f);
        apb(1'b0, 12'h004, 32'h0);
        check(rdata_q, 32'ha5);
        apb(1'b0, 12'h008, 32'h0);
        check(rdata_q, 32'h3c);
        apb(1'b0, 12'h000, 32'h0);
        check(rdata_q, 32'h81);
        // The clear lands on the access edge, so look one edge later
        @(posedge pclk);
        check(local_irq, 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h00);
        $display("Test master to local done");
        apb(1'b1, 12'h004, 32'h5a);
        apb(1'b1, 12'h008, 32'hc3);
        repeat (4) @(posedge pclk);
        check(mailbox_link_if_i.attention_request_n, 1'b1);
        check(attention, 1'b0);
        apb(1'b1, 12'h000, 32'h7e);
        repeat (4) @(posedge pclk);
        check(mailbox_link_if_i.attention_request_n, 1'b0);
        check(attention, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'hf0);
        link(1'b0, 2'h1, 8'h00);
        check(link_q, 8'h5a);
        apb(1'b0, 12'h004, 32'h0);
        check(rdata_q, 32'ha5);
        link(1'b0, 2'h2, 8'h00);
        check(link_q, 8'hc3);
        link(1'b0, 2'h0, 8'h00);
        check(link_q, 8'h7e);
        check(mailbox_link_if_i.attention_request_n, 1'b1);
        check(attention, 1'b0);
        link(1'b0, 2'h3, 8'h00);
        check(link_q, 8'h00);
        $display("Test local to master done");
        link(1'b1, 2'h1, 8'ha5);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h02);
        apb(1'b0, 12'h004, 32'h0);
        local_irq_enable <= 1'b0;
        link(1'b1, 2'h0, 8'h81);
        check(local_irq, 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h01);
        apb(1'b0, 12'h000, 32'h0);
        $display("Test rewrite and mask done");
        apb(1'b0, 12'h010, 32'h0);
        check(err_q, 1'b1);
        apb(1'b1, 12'h002, 32'h99);
        check(err_q, 1'b1);
        apb(1'b1, 12'h00c, 32'hff);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h00);
        link(1'b0, 2'h0, 8'h00);
        check(link_q, 8'h7e);
        local_irq_enable <= 1'b1;
        link(1'b1, 2'h0, 8'h11);
        check(local_irq, 1'b1);
        link(1'b1, 2'h3, 8'h00);
        check(local_irq, 1'b0);
        $display("Test refusals and status write done");
        port_enable <= 1'b0;
        gpio_out    <= 8'h96;
        link(1'b1, 2'h1, 8'h44);
        check(mailbox_link_if_i.slave_data_out, 8'h96);
        port_enable <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h01);
        $display("Test port disable done");
        apb(1'b1, 12'h000, 32'h3d);
        boot_mode_lo <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(boot_from_port, 1'b0);
        check(mailbox_link_if_i.attention_request_n, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata_q, 32'h00);
        $display("Test second reset done");
        close_out();
    end
endmodule : testbench
